// ---- rtl/oag_top.sv ----
// Operand and program-space address generator of the core
// Contract
// R1 - 24-bit program space, 16-bit data space
// R2 - Table access reaches every byte
// R3 - Window reads return low program word
// R4 - Table addresses need no alignment
// R5 - Table reads may target configuration space
// R6 - Eight move/accumulator operand modes
// R7 - Move source and destination modes differ
// R8 - One shared offset register field
// R9 - Reduced modes for dual-operand instructions
// R10 - Prefetch pointers only W8 to W11
// R11 - W8/W9 to X, W10/W11 to Y
// R12 - Pointers stay inside their data space; no X/Y bound is applied, pointer updates wrap at 16 bits
// R13 - Indexed only on W9 and W11
// R14 - Dual modes: indirect, post 2/4/6, indexed
// R15 - Branch literal is 16-bit signed
// R16 - Interrupt-disable literal 14-bit unsigned
// R17 - Implied operands; no-operation has none
// R18 - Table page above EA; fetch bits cleared
`timescale 1ns/10ps
`default_nettype none
module oag_top (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  instrValid,
    input  wire oag_pkg::oag_op_t      opcode,
    input  wire logic                  byteOp,
    input  wire oag_pkg::oag_mode_t    srcMode,
    input  wire oag_pkg::oag_mode_t    dstMode,
    input  wire logic [3:0]            srcReg,
    input  wire logic [3:0]            dstReg,
    input  wire logic [3:0]            offset_register_field,
    input  wire logic [15:0]           literal,
    input  wire logic [3:0]            xPtrSel,
    input  wire logic [3:0]            yPtrSel,
    input  wire oag_pkg::oag_mac_mode_t xMacMode,
    input  wire oag_pkg::oag_mac_mode_t yMacMode,
    input  wire logic [255:0]          wregFile,
    input  wire logic [7:0]            table_page_select,
    input  wire logic [22:0]           pcIn,
    input  wire logic [23:0]           progWordIn,
    output logic                       outValid,
    output logic [15:0]                srcEa,
    output logic [15:0]                dstEa,
    output logic [15:0]                srcWrBack,
    output logic                       srcWrBackEn,
    output logic [15:0]                dstWrBack,
    output logic                       dstWrBackEn,
    output logic [15:0]                xReadAddr,
    output logic [15:0]                yReadAddr,
    output logic [15:0]                xPtrNext,
    output logic [15:0]                yPtrNext,
    output logic                       dualModeErr,
    output logic [23:0]                tableAddr,
    output logic                       tableByteHigh,
    output logic                       tableCfgSpace,
    output logic                       tableWrite,
    output logic [23:0]                fetchAddr,
    output logic [15:0]                windowData,
    output logic [15:0]                branchOffset,
    output logic [13:0]                disableCount,
    output logic [3:0]                 impliedReg,
    output logic                       noOperand
);
    oag_ea_if srcIf ();
    oag_ea_if dstIf ();

    // Register file is flattened, W0 in the low bits
    wire logic [15:0] wreg [oag_pkg::WREG_N];
    genvar gi;
    generate
        for (gi = 0; gi < oag_pkg::WREG_N; gi++)
        begin : g_wreg
            assign wreg[gi] = wregFile[gi*16 +: 16];
        end
    endgenerate

    wire logic [15:0] offsetVal;
    assign offsetVal = wreg[offset_register_field];          // [R8]

    assign srcIf.base      = wreg[srcReg];                   // [R7]
    assign srcIf.offsetReg = offsetVal;                      // [R8]
    assign srcIf.lit       = literal;
    assign srcIf.mode      = srcMode;                        // [R6]
    assign srcIf.byteOp    = byteOp;
    assign dstIf.base      = wreg[dstReg];                   // [R7]
    assign dstIf.offsetReg = offsetVal;                      // [R8]
    assign dstIf.lit       = literal;
    assign dstIf.mode      = dstMode;                        // [R6]
    assign dstIf.byteOp    = byteOp;

    oag_ea_unit u_src (.port(srcIf.unit));
    oag_ea_unit u_dst (.port(dstIf.unit));

    // Dual-operand class
    wire logic isDual;
    assign isDual = (opcode >= oag_pkg::OAG_OP_CLR) &&
                    (opcode <= oag_pkg::OAG_OP_MSUB);        // [R9]

    function automatic logic [15:0] mac_step(
        input oag_pkg::oag_mac_mode_t m);
        unique case (m)
            oag_pkg::OAG_MAC_POST2: mac_step = oag_pkg::POST_BY2;
            oag_pkg::OAG_MAC_POST4: mac_step = oag_pkg::POST_BY4;
            oag_pkg::OAG_MAC_POST6: mac_step = oag_pkg::POST_BY6;
            default:                mac_step = 16'h0000;
        endcase
    endfunction

    // X side only sees W8/W9, Y side only W10/W11
    wire logic xSelOk;
    wire logic ySelOk;
    wire logic xModeOk;
    wire logic yModeOk;
    assign xSelOk = (xPtrSel == oag_pkg::W8) || (xPtrSel == oag_pkg::W9);
    assign ySelOk = (yPtrSel == oag_pkg::W10) ||
                    (yPtrSel == oag_pkg::W11);               // [R11]
    assign xModeOk = (xMacMode <= oag_pkg::OAG_MAC_INDEX) &&
                     ((xMacMode != oag_pkg::OAG_MAC_INDEX) ||
                      (xPtrSel == oag_pkg::W9));             // [R13] [R14]
    assign yModeOk = (yMacMode <= oag_pkg::OAG_MAC_INDEX) &&
                     ((yMacMode != oag_pkg::OAG_MAC_INDEX) ||
                      (yPtrSel == oag_pkg::W11));            // [R13] [R14]

    wire logic [15:0] xBase;
    wire logic [15:0] yBase;
    wire logic [15:0] next_xAddr;
    wire logic [15:0] next_yAddr;
    assign xBase = wreg[{2'b10, 1'b0, xPtrSel[0]}];          // [R11]
    assign yBase = wreg[{2'b10, 1'b1, yPtrSel[0]}];          // [R11]
    assign next_xAddr = (xMacMode == oag_pkg::OAG_MAC_INDEX) ?
                        xBase + offsetVal : xBase;           // [R14]
    assign next_yAddr = (yMacMode == oag_pkg::OAG_MAC_INDEX) ?
                        yBase + offsetVal : yBase;           // [R14]

    // Table and fetch address formation
    wire logic [23:0] next_tableAddr;
    wire logic        isTable;
    assign isTable = (opcode == oag_pkg::OAG_OP_TAB_RD) ||
                     (opcode == oag_pkg::OAG_OP_TAB_WR);
    assign next_tableAddr = {table_page_select, srcIf.ea};   // [R18] [R2]

    // Window read: low 16 bits of the program word only
    wire logic [15:0] next_window;
    assign next_window = progWordIn[15:0];                   // [R3] [R1]

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outValid      <= 1'b0;
            xReadAddr     <= 16'h0000;
            yReadAddr     <= 16'h0000;
            xPtrNext      <= 16'h0000;
            yPtrNext      <= 16'h0000;
            dualModeErr   <= 1'b0;
            branchOffset  <= 16'h0000;
            disableCount  <= 14'h0000;
            impliedReg    <= 4'h0;
            noOperand     <= 1'b0;
        end
        else
        begin
            outValid     <= instrValid;
            xReadAddr    <= next_xAddr;
            yReadAddr    <= next_yAddr;
            xPtrNext     <= xBase + mac_step(xMacMode);     // [R14]
            yPtrNext     <= yBase + mac_step(yMacMode);     // [R14]
            dualModeErr  <= instrValid && isDual &&
                            !(xSelOk && ySelOk && xModeOk && yModeOk);
            branchOffset <= (opcode == oag_pkg::OAG_OP_BRA) ?
                            literal : 16'h0000;              // [R15]
            disableCount <= (opcode == oag_pkg::OAG_OP_IDIS) ?
                            literal[13:0] : 14'h0000;        // [R16]
            impliedReg   <= (opcode == oag_pkg::OAG_OP_UNLINK) ?
                            oag_pkg::FRAME_PTR : 4'h0;       // [R17]
            noOperand    <= instrValid &&
                            (opcode == oag_pkg::OAG_OP_NOP); // [R17]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srcEa         <= 16'h0000;
            dstEa         <= 16'h0000;
            srcWrBack     <= 16'h0000;
            srcWrBackEn   <= 1'b0;
            dstWrBack     <= 16'h0000;
            dstWrBackEn   <= 1'b0;
            tableAddr     <= 24'h000000;
            tableByteHigh <= 1'b0;
            tableCfgSpace <= 1'b0;
            tableWrite    <= 1'b0;
            fetchAddr     <= 24'h000000;
            windowData    <= 16'h0000;
        end
        else
        begin
            srcEa         <= srcIf.ea;                       // [R6]
            dstEa         <= dstIf.ea;                       // [R7]
            srcWrBack     <= srcIf.wrBack;
            srcWrBackEn   <= instrValid && srcIf.wrBackEn;
            dstWrBack     <= dstIf.wrBack;
            dstWrBackEn   <= instrValid && dstIf.wrBackEn;
            tableAddr     <= next_tableAddr;                 // [R18] [R4]
            tableByteHigh <= srcIf.ea[0];                    // [R4]
            tableCfgSpace <= instrValid && isTable &&
                             (opcode == oag_pkg::OAG_OP_TAB_RD) &&
                             table_page_select[oag_pkg::CFG_PAGE_BIT]; // [R5]
            tableWrite    <= instrValid &&
                             (opcode == oag_pkg::OAG_OP_TAB_WR);
            fetchAddr     <= {1'b0, pcIn[22:1], 1'b0};       // [R18]
            windowData    <= next_window;                    // [R3]
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // The table-page, window, X-route and odd-byte antecedents sample rst_n so the release edge starts no attempt
    a_branch_sign: assert property ( // [R15]
        (opcode == oag_pkg::OAG_OP_BRA) |=> branchOffset == $past(literal))
        else $error("branch literal not passed");
    a_disable_lit: assert property ( // [R16]
        (opcode == oag_pkg::OAG_OP_IDIS) |=>
        disableCount == $past(literal[13:0]))
        else $error("disable literal wrong");
    a_fetch_bits: assert property ( // [R18]
        !fetchAddr[23] && !fetchAddr[0])
        else $error("fetch address bits not clear");
    a_table_page: assert property ( // [R18]
        rst_n |=> tableAddr[23:16] == $past(table_page_select))
        else $error("table page misplaced");
    a_window_low: assert property ( // [R3]
        rst_n |=> windowData == $past(progWordIn[15:0]))
        else $error("window data not low word");
    a_dual_index: assert property ( // [R13]
        (instrValid && isDual && xMacMode == oag_pkg::OAG_MAC_INDEX &&
         xPtrSel == oag_pkg::W8) |=> dualModeErr)
        else $error("indexed on W8 not flagged");
    a_x_route: assert property ( // [R11]
        (rst_n && xMacMode == oag_pkg::OAG_MAC_IND) |=>
        xReadAddr == $past(wreg[{3'b100, xPtrSel[0]}]))
        else $error("X pointer misrouted");
    a_nop_flag: assert property ( // [R17]
        (instrValid && opcode == oag_pkg::OAG_OP_NOP) |=> noOperand)
        else $error("no-operation not flagged");
    a_table_odd: assert property ( // [R4]
        (rst_n && srcMode == oag_pkg::OAG_INDIRECT) |=>
        tableByteHigh == $past(wreg[srcReg][0]))
        else $error("odd table byte lost");
endmodule : oag_top
`default_nettype wire

// ---- rtl/oag_pkg.sv ----
// Shared constants and types for the operand address generator
package oag_pkg;
    localparam int PS_ADDR_W   = 24;
    localparam int DS_DATA_W   = 16;
    localparam int PS_WORD_W   = 24;
    localparam int PAGE_W      = 8;
    localparam int WREG_N      = 16;
    localparam int WSEL_W      = 4;
    localparam int LIT8_W      = 8;
    localparam int LIT14_W     = 14;
    localparam logic [3:0] W8  = 4'h8;
    localparam logic [3:0] W9  = 4'h9;
    localparam logic [3:0] W10 = 4'hA;
    localparam logic [3:0] W11 = 4'hB;
    localparam logic [15:0] POST_BY2 = 16'h0002;
    localparam logic [15:0] POST_BY4 = 16'h0004;
    localparam logic [15:0] POST_BY6 = 16'h0006;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    // Top page bit selects configuration space for table reads
    localparam int CFG_PAGE_BIT = 7;
    // Window base: data addresses with bit 15 set reach program space
    localparam int WIN_BIT = 15;

    typedef enum logic [2:0] {
        OAG_REG_DIRECT = 3'h0,
        OAG_INDIRECT   = 3'h1,
        OAG_POST_MOD   = 3'h2,
        OAG_PRE_MOD    = 3'h3,
        OAG_INDEXED    = 3'h4,
        OAG_LIT_OFFSET = 3'h5,
        OAG_LIT8       = 3'h6,
        OAG_LIT16      = 3'h7
    } oag_mode_t;

    typedef enum logic [2:0] {
        OAG_MAC_IND    = 3'h0,
        OAG_MAC_POST2  = 3'h1,
        OAG_MAC_POST4  = 3'h2,
        OAG_MAC_POST6  = 3'h3,
        OAG_MAC_INDEX  = 3'h4
    } oag_mac_mode_t;

    typedef enum logic [3:0] {
        OAG_OP_MOVE    = 4'h0,
        OAG_OP_ACCUM   = 4'h1,
        OAG_OP_CLR     = 4'h2,
        OAG_OP_ED      = 4'h3,
        OAG_OP_EDIST   = 4'h4,
        OAG_OP_MAC     = 4'h5,
        OAG_OP_MPY     = 4'h6,
        OAG_OP_MPYN    = 4'h7,
        OAG_OP_MOVSTO  = 4'h8,
        OAG_OP_MSUB    = 4'h9,
        OAG_OP_BRA     = 4'hA,
        OAG_OP_IDIS    = 4'hB,
        OAG_OP_UNLINK  = 4'hC,
        OAG_OP_NOP     = 4'hD,
        OAG_OP_TAB_RD  = 4'hE,
        OAG_OP_TAB_WR  = 4'hF
    } oag_op_t;

    localparam logic [3:0] FRAME_PTR = 4'hE;
    localparam logic [3:0] STACK_PTR = 4'hF;
endpackage : oag_pkg

// ---- rtl/oag_ea_if.sv ----
// Carrier between the top and the effective-address unit
`timescale 1ns/10ps
`default_nettype none
interface oag_ea_if;
    logic [15:0]         base;
    logic [15:0]         offsetReg;
    logic [15:0]         lit;
    oag_pkg::oag_mode_t  mode;
    logic                byteOp;
    logic [15:0]         ea;
    logic [15:0]         wrBack;
    logic                wrBackEn;
    modport owner (output base, offsetReg, lit, mode, byteOp,
                   input ea, wrBack, wrBackEn);
    modport unit  (input base, offsetReg, lit, mode, byteOp,
                   output ea, wrBack, wrBackEn);
endinterface : oag_ea_if
`default_nettype wire

// ---- rtl/oag_ea_unit.sv ----
// One effective-address calculator for move and accumulator operands
`timescale 1ns/10ps
`default_nettype none
module oag_ea_unit (
    oag_ea_if.unit port
);
    wire logic [15:0] step;
    wire logic [15:0] incd;
    assign step = port.byteOp ? oag_pkg::STEP_BYTE : oag_pkg::STEP_WORD;
    assign incd = port.base + step;
    always_comb
    begin
        port.ea       = port.base;
        port.wrBack   = port.base;
        port.wrBackEn = 1'b0;
        unique case (port.mode)
            oag_pkg::OAG_REG_DIRECT: port.ea = port.base;
            oag_pkg::OAG_INDIRECT:   port.ea = port.base;
            oag_pkg::OAG_POST_MOD:
            begin
                port.ea       = port.base;
                port.wrBack   = incd;
                port.wrBackEn = 1'b1;
            end
            oag_pkg::OAG_PRE_MOD:
            begin
                port.ea       = incd;
                port.wrBack   = incd;
                port.wrBackEn = 1'b1;
            end
            oag_pkg::OAG_INDEXED:    port.ea = port.base + port.offsetReg;
            oag_pkg::OAG_LIT_OFFSET: port.ea = port.base + port.lit;
            oag_pkg::OAG_LIT8:       port.ea = {8'h00, port.lit[7:0]};
            oag_pkg::OAG_LIT16:      port.ea = port.lit;
        endcase
    end
endmodule : oag_ea_unit
`default_nettype wire

// ---- verif/oag_core_model.sv ----
// Behavioural working-register file of the core facing the generator
`timescale 1ns/10ps
`default_nettype none
module oag_core_model (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          instrValid,
    input  wire logic [3:0]    srcReg,
    input  wire logic [15:0]   srcWrBack,
    input  wire logic          srcWrBackEn,
    output logic      [255:0]  wregFile
);
    logic [15:0] wreg [16];
    logic [3:0]  lastSrc;

    // Odd start values so plain table accesses land on high bytes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                wreg[i] <= {4'h1, 4'(i), 8'h31};
            lastSrc <= 4'h0;
        end
        else
        begin
            if (instrValid)
                lastSrc <= srcReg;
            // Updated pointer is written back where it came
            if (srcWrBackEn)
                wreg[lastSrc] <= srcWrBack;
        end
    end

    always_comb
        for (int i = 0; i < 16; i++)
            wregFile[i*16 +: 16] = wreg[i];
endmodule // oag_core_model
`default_nettype wire

// ---- verif/oag_top_test.sv ----
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module oag_top_test;
    logic                   sys_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   instrValid = 1'b0;
    logic                   byteOp = 1'b0;
    oag_pkg::oag_op_t       opcode = oag_pkg::OAG_OP_NOP;
    oag_pkg::oag_mode_t     srcMode = oag_pkg::OAG_INDIRECT;
    oag_pkg::oag_mode_t     dstMode = oag_pkg::OAG_INDIRECT;
    oag_pkg::oag_mac_mode_t xMacMode = oag_pkg::OAG_MAC_IND;
    oag_pkg::oag_mac_mode_t yMacMode = oag_pkg::OAG_MAC_IND;
    logic [3:0]             srcReg = 4'h0, dstReg = 4'h0;
    logic [3:0]             offset_register_field = 4'h0;
    logic [3:0]             xPtrSel = 4'h8, yPtrSel = 4'hA;
    logic [15:0]            literal = 16'h0000;
    logic [7:0]             table_page_select = 8'h00;
    logic [22:0]            pcIn = 23'h000000;
    logic [23:0]            progWordIn = 24'h000000;
    logic [255:0]           wregFile;
    logic [15:0]            srcEa, dstEa, srcWrBack, dstWrBack, xReadAddr;
    logic [15:0]            yReadAddr, xPtrNext, yPtrNext, windowData;
    logic [15:0]            branchOffset;
    logic [23:0]            tableAddr, fetchAddr;
    logic [13:0]            disableCount;
    logic [3:0]             impliedReg;
    logic                   outValid, srcWrBackEn, dstWrBackEn, dualModeErr;
    logic                   tableByteHigh, tableCfgSpace, tableWrite;
    logic                   noOperand;
    logic [15:0]            ev [16];
    int                     numErrors = 0;
    int                     nCompared = 0;

    always #10 sys_clk = ~sys_clk;

    oag_top uut (.sys_clk, .rst_n, .instrValid, .opcode, .byteOp, .srcMode,
        .dstMode, .srcReg, .dstReg, .offset_register_field, .literal,
        .xPtrSel, .yPtrSel, .xMacMode, .yMacMode, .wregFile,
        .table_page_select, .pcIn, .progWordIn, .outValid, .srcEa, .dstEa,
        .srcWrBack, .srcWrBackEn, .dstWrBack, .dstWrBackEn, .xReadAddr,
        .yReadAddr, .xPtrNext, .yPtrNext, .dualModeErr, .tableAddr,
        .tableByteHigh, .tableCfgSpace, .tableWrite, .fetchAddr,
        .windowData, .branchOffset, .disableCount, .impliedReg, .noOperand);

    oag_core_model core (.sys_clk, .rst_n, .instrValid, .srcReg,
        .srcWrBack, .srcWrBackEn, .wregFile);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Called right after a rising edge; outputs settle one cycle later
    task automatic issue(input oag_pkg::oag_op_t op,
            input oag_pkg::oag_mode_t sm, input oag_pkg::oag_mode_t dm,
            input logic [3:0] sr, input logic [15:0] lit, input logic bo);
        instrValid <= 1'b1;
        opcode <= op;
        srcMode <= sm;
        dstMode <= dm;
        srcReg <= sr;
        dstReg <= 4'h4;
        literal <= lit;
        byteOp <= bo;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
    endtask

    task automatic t_move();
        @(posedge sys_clk);
        offset_register_field <= 4'h5;
        issue(oag_pkg::OAG_OP_MOVE, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDEXED, 4'h3, 16'h0000, 1'b0);
        chk(srcEa, ev[3]);
        chk(outValid, 1'b1);
        chk(dstEa, ev[4] + ev[5]);
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_ACCUM, oag_pkg::OAG_LIT_OFFSET,
              oag_pkg::OAG_INDIRECT, 4'h6, 16'h0040, 1'b0);
        chk(srcEa, ev[6] + 16'h0040);
        chk(dstEa, ev[4]);
        // Word step then byte step, pointer carried back by the core
        for (int b = 0; b < 2; b++)
        begin
            @(posedge sys_clk);
            issue(oag_pkg::OAG_OP_MOVE, oag_pkg::OAG_POST_MOD,
                  oag_pkg::OAG_INDIRECT, 4'h2, 16'h0000, b[0]);
            chk(srcEa, ev[2]);
            chk(srcWrBackEn, 1'b1);
            ev[2] = ev[2] + (b[0] ? 16'h0001 : 16'h0002);
            chk(srcWrBack, ev[2]);
        end
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_MOVE, oag_pkg::OAG_PRE_MOD,
              oag_pkg::OAG_INDIRECT, 4'hC, 16'h0000, 1'b0);
        ev[12] = ev[12] + 16'h0002;
        chk(srcEa, ev[12]);
        chk(srcWrBack, ev[12]);
        chk(srcWrBackEn, 1'b1);
        // Direct and literal forms never move a pointer
        for (int m = 0; m < 3; m++)
        begin
            @(posedge sys_clk);
            issue(oag_pkg::OAG_OP_MOVE, m == 0 ? oag_pkg::OAG_REG_DIRECT :
                  m == 1 ? oag_pkg::OAG_LIT8 : oag_pkg::OAG_LIT16,
                  oag_pkg::OAG_INDIRECT, 4'h2, 16'h1234, 1'b0);
            chk(srcWrBackEn, 1'b0);
            chk(srcEa, m == 0 ? ev[2] : m == 1 ? 16'h0034 : 16'h1234);
        end
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_MOVE, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_PRE_MOD, 4'h2, 16'h0000, 1'b0);
        chk(srcEa, ev[2]);
        chk(dstEa, ev[4] + 16'h0002);
        chk(dstWrBack, ev[4] + 16'h0002);
        chk(dstWrBackEn, 1'b1);
    endtask

    task automatic dual(input int op, input logic [3:0] xs,
            input logic [3:0] ys, input oag_pkg::oag_mac_mode_t xm,
            input oag_pkg::oag_mac_mode_t ym, input logic [3:0] ofs);
        @(posedge sys_clk);
        xPtrSel <= xs;
        yPtrSel <= ys;
        xMacMode <= xm;
        yMacMode <= ym;
        offset_register_field <= ofs;
        issue(oag_pkg::oag_op_t'(4'(op)), oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDIRECT, 4'h3, 16'h0000, 1'b0);
    endtask

    task automatic t_dual();
        for (int op = 2; op <= 9; op++)
        begin
            dual(op, 4'h8, 4'hA, oag_pkg::OAG_MAC_IND,
                 oag_pkg::OAG_MAC_POST4, 4'h0);
            chk(xReadAddr, ev[8]);
            chk(yReadAddr, ev[10]);
            chk(yPtrNext, ev[10] + 16'h0004);
            chk(dualModeErr, 1'b0);
        end
        dual(5, 4'h9, 4'hB, oag_pkg::OAG_MAC_INDEX,
             oag_pkg::OAG_MAC_POST6, 4'h5);
        chk(xReadAddr, ev[9] + ev[5]);
        chk(yPtrNext, ev[11] + 16'h0006);
        dual(6, 4'h9, 4'hB, oag_pkg::OAG_MAC_POST2,
             oag_pkg::OAG_MAC_INDEX, 4'h6);
        chk(xPtrNext, ev[9] + 16'h0002);
        chk(yReadAddr, ev[11] + ev[6]);
        chk(dualModeErr, 1'b0);
        dual(5, 4'h8, 4'hA, oag_pkg::OAG_MAC_INDEX,
             oag_pkg::OAG_MAC_IND, 4'h5);
        chk(dualModeErr, 1'b1);
        dual(5, 4'h8, 4'hA, oag_pkg::OAG_MAC_IND,
             oag_pkg::OAG_MAC_INDEX, 4'h5);
        chk(dualModeErr, 1'b1);
        // Deliberately illegal: a Y pointer offered to the X side
        dual(5, 4'hA, 4'hB, oag_pkg::OAG_MAC_IND,
             oag_pkg::OAG_MAC_IND, 4'h5);
        chk(dualModeErr, 1'b1);
    endtask

    task automatic t_table();
        logic [7:0]  pg;
        logic [15:0] ea;
        for (int k = 0; k < 2; k++)
        begin
            pg = k ? 8'h85 : 8'h92;
            ea = k ? ev[3] : ev[3] + 16'h0001;
            @(posedge sys_clk);
            table_page_select <= pg;
            issue(k ? oag_pkg::OAG_OP_TAB_RD : oag_pkg::OAG_OP_TAB_WR,
                  k ? oag_pkg::OAG_INDIRECT : oag_pkg::OAG_LIT_OFFSET,
                  oag_pkg::OAG_INDIRECT, 4'h3, 16'h0001, 1'b0);
            chk(tableAddr, {pg, ea});
            chk(tableByteHigh, ea[0]);
            chk(tableCfgSpace, k[0]);
            chk(tableWrite, !k[0]);
            chk(dualModeErr, 1'b0);
        end
    endtask

    task automatic t_misc();
        @(posedge sys_clk);
        pcIn <= 23'h7ABCDF;
        progWordIn <= 24'hA5C33C;
        issue(oag_pkg::OAG_OP_BRA, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDIRECT, 4'h0, 16'h8001, 1'b0);
        chk(fetchAddr, 24'h7ABCDE);
        chk(windowData, 16'hC33C);
        chk(branchOffset, 16'h8001);
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_IDIS, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDIRECT, 4'h0, 16'hFFFF, 1'b0);
        chk(disableCount, 14'h3FFF);
        chk(branchOffset, 16'h0000);
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_UNLINK, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDIRECT, 4'h0, 16'h0000, 1'b0);
        chk(impliedReg, 4'hE);
        chk(noOperand, 1'b0);
        @(posedge sys_clk);
        issue(oag_pkg::OAG_OP_NOP, oag_pkg::OAG_INDIRECT,
              oag_pkg::OAG_INDIRECT, 4'h0, 16'h0000, 1'b0);
        chk(noOperand, 1'b1);
        chk(impliedReg, 4'h0);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        numErrors++;
        report_and_stop();
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
            ev[i] = {4'h1, 4'(i), 8'h31};
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_move();
        t_dual();
        t_table();
        t_misc();
        report_and_stop();
    end
endmodule // oag_top_test
`default_nettype wire
